// ### bench/sas_checker.sv
// Pin-level checks on the SDRAM access sequencer
`timescale 1ns/1ps
module sas_checker import sas_pkg::*; (
  input wire logic clock_i, resetn_i, ras_n_o, cas_n_o, we_n_o, dq_oe_o, rd_valid_o,
  input wire logic bus_cycle_start_strobe_o, bank_active_enable_i,
  input wire logic area2_latency_hi_i, area2_latency_lo_i,
  input wire logic [1:0] row_to_col_delay_i,
  input wire logic [PIN_W-1:0] sd_addr_o
);
  wire [2:0] cmd = {ras_n_o, cas_n_o, we_n_o};
  wire col = cmd == CMD_READ || cmd == CMD_WRIT;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  sequence rd_cmd; cmd == CMD_READ; endsequence
  // Each command is tied to its cause; a slip in spacing shows as a wrong code
  cmd_legal_a: assert property (cmd != 3'h0 && cmd != 3'h6)
    else $error("bad command");
  gap_fill_a: assert property (cmd == CMD_ACTV && |row_to_col_delay_i |=> cmd == CMD_NOP)
    else $error("no fill");
  gap_zero_a: assert property (cmd == CMD_ACTV && row_to_col_delay_i == 2'h0 |=> col)
    else $error("column late");
  pre_gap_a: assert property (cmd == CMD_PRE |=> cmd == CMD_NOP)
    else $error("activate early");
  wr_data_a: assert property (cmd == CMD_WRIT |-> dq_oe_o && bus_cycle_start_strobe_o)
    else $error("no write data");
  rd_strobe_a: assert property (rd_valid_o |-> $past(bus_cycle_start_strobe_o))
    else $error("no strobe");
  open_row_a: assert property (bank_active_enable_i && col |-> !sd_addr_o[10])
    else $error("row closed");
  cas_lat_a: assert property (rd_cmd ##0 {area2_latency_hi_i, area2_latency_lo_i} == 2'h2
    |-> ##2 bus_cycle_start_strobe_o) else $error("late capture");
endmodule : sas_checker

bind sas_sequencer sas_checker sas_checker_inst (.clock_i, .resetn_i, .ras_n_o, .cas_n_o,
  .we_n_o, .dq_oe_o, .rd_valid_o, .bus_cycle_start_strobe_o, .bank_active_enable_i,
  .area2_latency_hi_i, .area2_latency_lo_i, .row_to_col_delay_i, .sd_addr_o);

// ### bench/sas_sdram_model.sv
// Behavioural SDRAM array answering the sequencer
`timescale 1ns/1ps
module sas_sdram_model import sas_pkg::*; (
  input wire logic clock_i, ras_n_i, cas_n_i, we_n_i,
  input wire logic [1:0] lat_i,
  input wire logic [PIN_W-1:0] addr_i,
  input wire logic [MASK_W-1:0] mask_i,
  input wire logic [DATA_W-1:0] wdata_i,
  output logic [DATA_W-1:0] rdata_o = '0
);
  logic [DATA_W-1:0] mem [16] = '{default: 0};
  logic [DATA_W-1:0] pd [3];
  logic [2:0] pv = 3'h0;
  wire [2:0] cmd = {ras_n_i, cas_n_i, we_n_i};
  // Lanes with a low mask take the data sent with the command
  always @(posedge clock_i) begin
    for (int i = 0; i < MASK_W; i++)
      if (cmd == CMD_WRIT && !mask_i[i]) mem[addr_i[5:2]][8*i+:8] <= wdata_i[8*i+:8];
    pv <= {pv[1:0], cmd == CMD_READ};
    pd <= '{mem[addr_i[5:2]], pd[0], pd[1]};
  end
  // Data stands one cycle; otherwise the bus toggles so stale values never match
  always @(negedge clock_i) rdata_o <= pv[lat_i - 2'h1] ? pd[lat_i - 2'h1] : ~rdata_o;
endmodule : sas_sdram_model

// ### bench/sas_sequencer_bench.sv
// Self-checking bench for the SDRAM access sequencer
`timescale 1ns/1ps
module sas_sequencer_bench;
  import sas_pkg::*;
  logic clock_i = 0, resetn_i = 0, req_valid_i = 0, wr_valid_i = 0, rba = 0, rfq = 0;
  logic rel = 0, rsm = 0, big = 0;
  logic [1:0] lat = 2'h2, r2c = 2'h1;
  logic [31:0] wr_data_i = '0, e1 [4] = '{32'h9bde1234, 0, 0, 0};
  sas_req_type req_i = '0;
  wire [31:0] dq_i, dq_o, rd_data_o;
  wire [13:0] sd_addr_o;
  wire [3:0] mask;
  wire req_ready_o, wr_ready_o, rd_valid_o, ras_n_o, cas_n_o, we_n_o, cke;
  int n_fail = 0, num_checks = 0, n_act = 0, n_ref = 0;
  // Toggle each half period for 200 MHz
  always #2.5 clock_i = ~clock_i;
  sas_sequencer sas_sequencer_inst (.clock_i, .resetn_i, .req_valid_i, .req_i, .req_ready_o,
    .wr_valid_i, .wr_data_i, .wr_ready_o, .rd_valid_o, .rd_data_o, .row_to_col_delay_i(r2c),
    .precharge_wait_i(3'h2), .write_recovery_i(3'h1), .row_active_time_i(3'h2),
    .area2_latency_hi_i(lat[1]), .area2_latency_lo_i(lat[0]), .area3_latency_hi_i(lat[1]),
    .area3_latency_lo_i(lat[0]), .bank_active_enable_i(rba), .refresh_mode_select_i(rsm),
    .refresh_enable_i(1'b1), .refresh_req_i(rfq), .bus_release_i(rel), .big_endian_i(big),
    .bus16_i(1'b0), .sd_addr_o, .ras_n_o, .cas_n_o, .we_n_o, .cke_o(cke), .dq_o, .dq_oe_o(),
    .dq_i, .byte_mask_outputs_o(mask), .bus_cycle_start_strobe_o());
  sas_sdram_model sas_sdram_model_inst (.clock_i, .ras_n_i(ras_n_o), .cas_n_i(cas_n_o),
    .we_n_i(we_n_o), .lat_i(lat), .addr_i(sd_addr_o), .mask_i(mask), .wdata_i(dq_o),
    .rdata_o(dq_i));
  // Count activates and refreshes seen on the pins
  always @(posedge clock_i) begin
    n_act += resetn_i && {ras_n_o, cas_n_o, we_n_o} == CMD_ACTV;
    n_ref += resetn_i && {ras_n_o, cas_n_o, we_n_o} == CMD_REF;
  end
  task automatic step;
    @(posedge clock_i);
    #1;
  endtask : step
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // Request held until taken; a stuck ready counts as a mismatch
  task automatic req(input logic w, b, input logic [3:0] be, input logic [25:0] a);
    req_i = '{w, b, 1'b0, be, a};
    req_valid_i = 1;
    for (int n = 0; n < 60 && req_ready_o !== 1; n++) step;
    check(req_ready_o, 1);
    step;
    req_valid_i = 0;
    step;
  endtask : req
  task automatic rd(input logic b, input logic [25:0] a, input logic [31:0] e [4]);
    int k;
    k = 0;
    req(0, b, 4'hf, a);
    repeat (24) begin
      if (rd_valid_o === 1) begin
        check(rd_data_o, e[k%4]);
        k++;
      end
      step;
    end
    check(32'(k), b ? 4 : 1);
  endtask : rd
  // Fill the FIFO until it refuses, drain by two wrapped bursts, read back wrapped
  task automatic t_burst;
    wr_valid_i = 1;
    for (int i = 0; i < 8; i++) begin
      wr_data_i = 32'hc0de0000 + i;
      step;
    end
    wr_valid_i = 0;
    check(wr_ready_o, 0);
    req(1, 1, 4'hf, 26'h4);
    req(1, 1, 4'hf, 26'h14);
    check(wr_ready_o, 1);
    rd(1, 26'h8, '{32'hc0de0001, 32'hc0de0002, 32'hc0de0003, 32'hc0de0000});
  endtask : t_burst
  task automatic t_single;
    wr_valid_i = 1;
    wr_data_i = 32'h5a5a1234;
    step;
    wr_data_i = 32'h9b000000;
    step;
    wr_valid_i = 0;
    req(1, 0, 4'h3, 26'h1c);
    big = 1;
    req(1, 0, 4'h1, 26'h1c);
    big = 0;
    rd(0, 26'h1c, e1);
  endtask : t_single
  // Open rows: hit, miss, then refresh closes everything
  task automatic t_open;
    int a0;
    rba = 1;
    lat = 2'h1;
    r2c = 2'h0;
    a0 = n_act;
    rd(0, 26'h1c, e1);
    rd(0, 26'h1c, e1);
    check(n_act - a0, 1);
    rd(0, 26'h41c, e1);
    check(n_act - a0, 2);
    rfq = 1;
    step;
    rfq = 0;
    rd(0, 26'h1c, e1);
    check(n_act - a0, 3);
    check(n_ref, 1);
    rel = 1;
    step;
    rel = 0;
    rd(0, 26'h1c, e1);
    check(n_act - a0, 4);
    rsm = 1;
    repeat (6) step;
    check(cke, 0);
    rsm = 0;
    rd(0, 26'h1c, e1);
    check(n_act - a0, 5);
    check(n_ref, 2);
  endtask : t_open
  task automatic summarize;
    $display("checks=%0d failures=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  initial begin
    repeat (6) @(posedge clock_i);
    #1 resetn_i = 1;
    step;
    t_burst;
    t_single;
    t_open;
    summarize;
  end
  // Tests need well under 1000 cycles
  initial begin
    #20000;
    n_fail++;
    summarize;
  end
endmodule : sas_sequencer_bench

// ### design/sas_pkg.sv
// Shared constants, types and address helpers for the SDRAM access sequencer
package sas_pkg;

  // ***************************************************************
  // Widths and field positions
  // ***************************************************************
  localparam int ADDR_W   = 26;
  localparam int PIN_W    = 14;
  localparam int DATA_W   = 32;
  localparam int MASK_W   = 4;
  localparam int BANK_LSB = 19;
  localparam int BANK_W   = 2;
  localparam int TAG_W    = 14;
  localparam int CNT_W    = 4;
  localparam int BEAT_W   = 3;

  // ***************************************************************
  // Commands as {ras_n, cas_n, we_n}, chip select held low outside
  // ***************************************************************
  localparam logic [2:0] CMD_NOP  = 3'h7;
  localparam logic [2:0] CMD_ACTV = 3'h3;
  localparam logic [2:0] CMD_READ = 3'h5;
  localparam logic [2:0] CMD_WRIT = 3'h4;
  localparam logic [2:0] CMD_PRE  = 3'h2;
  localparam logic [2:0] CMD_REF  = 3'h1;

  // ***************************************************************
  // Byte masks, last beat of each burst and the minimum latency
  // ***************************************************************
  localparam logic [MASK_W-1:0] MASK_NONE   = 4'hf;
  localparam logic [MASK_W-1:0] MASK_ALL    = 4'h0;
  localparam logic [BEAT_W-1:0] LAST_BEAT32 = 3'h3;
  localparam logic [BEAT_W-1:0] LAST_BEAT16 = 3'h7;
  localparam logic [1:0]        LAT_MIN     = 2'h1;

  typedef struct packed {
    logic              write;
    logic              burst;
    logic              area3;
    logic [MASK_W-1:0] byte_en;
    logic [ADDR_W-1:0] addr;
  } sas_req_type;

  // Row phase pins: A2-A9 <= A10-A17, A10 <= A18, A11 <= A19
  function automatic logic [PIN_W-1:0] row_pins(input logic [ADDR_W-1:0] a);
    row_pins = {a[21], a[20], a[19], a[18], a[17:10], a[9], a[0]};
  endfunction : row_pins

  // Column phase pins: A10 carries the auto-precharge level
  function automatic logic [PIN_W-1:0] col_pins(input logic [ADDR_W-1:0] a,
                                                input logic ap);
    col_pins = {a[21], a[20], a[19], ap, a[9:2], a[1], a[0]};
  endfunction : col_pins

  // Precharge pins: A10 high precharges all banks
  function automatic logic [PIN_W-1:0] pre_pins(input logic [ADDR_W-1:0] a,
                                                input logic all);
    pre_pins = {a[21], a[20], a[19], all, 10'h000};
  endfunction : pre_pins

  function automatic logic [TAG_W-1:0] row_tag(input logic [ADDR_W-1:0] a);
    row_tag = {a[25:21], a[18:10]};
  endfunction : row_tag

  // Wraparound column address inside the 16-byte unit
  function automatic logic [ADDR_W-1:0] wrap_addr(input logic [ADDR_W-1:0] a,
                                                  input logic [BEAT_W-1:0] b,
                                                  input logic b16);
    wrap_addr = a;
    if (b16) begin
      wrap_addr[3:1] = a[3:1] + b;
    end else begin
      wrap_addr[3:2] = a[3:2] + b[1:0];
    end
  endfunction : wrap_addr

  // Byte masks, active low, bit 3 is the most significant lane
  function automatic logic [MASK_W-1:0] lane_mask(input logic [MASK_W-1:0] be,
                                                  input logic big);
    for (int i = 0; i < MASK_W; i++) begin
      lane_mask[i] = big ? ~be[MASK_W-1-i] : ~be[i];
    end
  endfunction : lane_mask

endpackage : sas_pkg

// ### design/sas_sequencer.sv
// SDRAM access sequencer with its write-data FIFO
// Notes on behaviour
// - Mux 011 on 32 bits: row phase A10-A17, column phase A2-A9 on pins A2-A9.
// - Pin A11 carries A19 in both phases; A10 carries A18, then precharge level.
// - Burst read: ACTV, READ three times, READA last, capture four beats.
// - After auto-precharge wait the precharge time before touching that bank.
// - Row-to-column delay field 0..3 gives 1..4 cycles.
// - Extra row-to-column cycles carry NOP.
// - Read capture 1..3 cycles after command, per area latency setting.
// - Bus-cycle-start strobe pulses in every data cycle.
// - Burst covers 16 bytes; only A3:A2 (A3:A1 on 16 bits) change.
// - Line fill starts at the missed word and wraps.
// - Single reads move one word only.
// - Burst write: ACTV, WRIT three times, WRITA last, data with command.
// - Single write: ACTV then WRITA with data.
// - After write auto-precharge add write recovery before precharge wait.
// - Bank-active mode uses commands without auto-precharge, row stays open.
// - Open row hit goes straight to WRIT, or to READ when latency is above one.
// - Open row miss: PRE, ACTV, then column command.
// - PRE to ACTV spacing is the precharge wait.
// - One open row remembered per bank.
// - Latency one adds a NOP before a row-hit READ.
// - Refresh and bus release close every bank.
// - Refresh enable alone: auto-refresh; with mode bit: self-refresh.
// - Low byte mask enables a lane; endian picks lane order.
// - Refresh: precharge all, REF after wait, hold row-active plus wait.
`timescale 1ns/1ps

// ***************************************************************
// Write-data FIFO
// ***************************************************************
module sas_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input  wire logic                       clock_i,
  input  wire logic                       resetn_i,
  input  wire logic                       in_valid_i,
  output logic                            in_ready_o,
  input  wire logic [WIDTH-1:0]           in_data_i,
  output logic                            out_valid_o,
  input  wire logic                       out_ready_i,
  output logic [WIDTH-1:0]                out_data_o,
  output logic [$clog2(DEPTH+1)-1:0]      level_o
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0]             mem_ff [DEPTH];
  logic [PW-1:0]                wptr_ff;
  logic [PW-1:0]                rptr_ff;
  logic [$clog2(DEPTH+1)-1:0]   level_ff;
  logic                         push;
  logic                         pop;

  assign in_ready_o  = (level_ff != DEPTH[$clog2(DEPTH+1)-1:0]);
  assign out_valid_o = (level_ff != '0);
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_ready_i && out_valid_o;
  assign out_data_o  = mem_ff[rptr_ff];
  assign level_o     = level_ff;

  // Storage has no reset; only pointers and fill level carry state
  always_ff @(posedge clock_i) begin
    if (push) begin
      mem_ff[wptr_ff] <= in_data_i;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wptr_ff  <= '0;
      rptr_ff  <= '0;
      level_ff <= '0;
    end else begin
      if (push) begin
        wptr_ff <= (wptr_ff == PW'(DEPTH - 1)) ? '0 : wptr_ff + 1'b1;
      end
      if (pop) begin
        rptr_ff <= (rptr_ff == PW'(DEPTH - 1)) ? '0 : rptr_ff + 1'b1;
      end
      level_ff <= level_ff + {{($clog2(DEPTH+1)-1){1'b0}}, push}
                           - {{($clog2(DEPTH+1)-1){1'b0}}, pop};
    end
  end
endmodule : sas_fifo

// ***************************************************************
// Sequencer
// ***************************************************************
module sas_sequencer #(
  parameter int BANKS      = 4,
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic                       clock_i,
  input  wire logic                       resetn_i,
  input  wire logic                       req_valid_i,
  input  wire sas_pkg::sas_req_type       req_i,
  output logic                            req_ready_o,
  input  wire logic                       wr_valid_i,
  input  wire logic [sas_pkg::DATA_W-1:0] wr_data_i,
  output logic                            wr_ready_o,
  output logic                            rd_valid_o,
  output logic [sas_pkg::DATA_W-1:0]      rd_data_o,
  input  wire logic [1:0]                 row_to_col_delay_i,
  input  wire logic [2:0]                 precharge_wait_i,
  input  wire logic [2:0]                 write_recovery_i,
  input  wire logic [2:0]                 row_active_time_i,
  input  wire logic                       area2_latency_hi_i,
  input  wire logic                       area2_latency_lo_i,
  input  wire logic                       area3_latency_hi_i,
  input  wire logic                       area3_latency_lo_i,
  input  wire logic                       bank_active_enable_i,
  input  wire logic                       refresh_mode_select_i,
  input  wire logic                       refresh_enable_i,
  input  wire logic                       refresh_req_i,
  input  wire logic                       bus_release_i,
  input  wire logic                       big_endian_i,
  input  wire logic                       bus16_i,
  output logic [sas_pkg::PIN_W-1:0]       sd_addr_o,
  output logic                            ras_n_o,
  output logic                            cas_n_o,
  output logic                            we_n_o,
  output logic                            cke_o,
  output logic [sas_pkg::DATA_W-1:0]      dq_o,
  output logic                            dq_oe_o,
  input  wire logic [sas_pkg::DATA_W-1:0] dq_i,
  output logic [sas_pkg::MASK_W-1:0]      byte_mask_outputs_o,
  output logic                            bus_cycle_start_strobe_o
);
  import sas_pkg::*;

  typedef enum logic [9:0] {
    ST_IDLE  = 10'h001,
    ST_TPC   = 10'h002,
    ST_ACT   = 10'h004,
    ST_GAP   = 10'h008,
    ST_NOP   = 10'h010,
    ST_COL   = 10'h020,
    ST_DRAIN = 10'h040,
    ST_RFT   = 10'h080,
    ST_RFH   = 10'h100,
    ST_SELF  = 10'h200
  } sas_state_type;

  sas_state_type              state_ff;
  sas_state_type              nxt_state;
  sas_req_type                req_ff;
  sas_req_type                cur;
  logic [CNT_W-1:0]           cnt_ff;
  logic [CNT_W-1:0]           nxt_cnt;
  logic [BEAT_W-1:0]          beat_ff;
  logic [BEAT_W-1:0]          nxt_beat;
  logic [BEAT_W-1:0]          last_beat;
  logic [2:0]                 cmd_ff;
  logic [2:0]                 nxt_cmd;
  logic [PIN_W-1:0]           pin_ff;
  logic [PIN_W-1:0]           nxt_pin;
  logic                       cke_ff;
  logic                       nxt_cke;
  logic [DATA_W-1:0]          dq_ff;
  logic                       dq_oe_ff;
  logic [MASK_W-1:0]          bmask_ff;
  logic [2:0]                 rd_pipe_ff;
  logic [1:0]                 lat_ff;
  logic [1:0]                 lat_now;
  logic [DATA_W-1:0]          rd_data_ff;
  logic                       rd_valid_ff;
  logic                       ref_pend_ff;
  logic                       capture;
  logic                       take;
  logic                       go_col;
  logic                       ld_busy;
  logic                       close_all;
  logic                       ref_due;
  logic                       all_free;
  logic                       hit;
  logic                       pop;
  logic                       fifo_valid;
  logic [DATA_W-1:0]          fifo_data;
  logic [$clog2(FIFO_DEPTH+1)-1:0] fifo_level;
  logic [BANK_W-1:0]          bank;
  logic [BANK_W-1:0]          req_bank;
  logic [BANKS-1:0]           open_ff;
  logic [BANKS-1:0]           free;
  logic [TAG_W-1:0]           row_ff [BANKS];
  logic [CNT_W-1:0]           busy_ff [BANKS];
  logic [CNT_W-1:0]           tpc_cnt;
  logic [CNT_W-1:0]           busy_val;
  logic [CNT_W-1:0]           req_beats;

  // ***************************************************************
  // Write data buffer; the sequencer drains one word per write beat
  // ***************************************************************
  sas_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_wfifo (
    .clock_i     (clock_i),
    .resetn_i    (resetn_i),
    .in_valid_i  (wr_valid_i),
    .in_ready_o  (wr_ready_o),
    .in_data_i   (wr_data_i),
    .out_valid_o (fifo_valid),
    .out_ready_i (pop),
    .out_data_o  (fifo_data),
    .level_o     (fifo_level)
  );

  // Decode of the live request and timing settings
  assign cur       = (state_ff == ST_IDLE) ? req_i : req_ff;
  assign bank      = cur.addr[BANK_LSB +: BANK_W];
  assign req_bank  = req_i.addr[BANK_LSB +: BANK_W];
  assign last_beat = !cur.burst ? '0 : (bus16_i ? LAST_BEAT16 : LAST_BEAT32);
  assign req_beats = !req_i.burst ? CNT_W'(1) : (bus16_i ? CNT_W'(8) : CNT_W'(4));
  assign tpc_cnt   = (precharge_wait_i == '0) ? CNT_W'(1) : CNT_W'(precharge_wait_i);
  assign hit       = bank_active_enable_i && open_ff[bank]
                     && (row_ff[bank] == row_tag(cur.addr));
  assign all_free  = (free == '1);
  // A zero latency code is treated as one so that capture still happens
  assign lat_now   = req_i.area3 ? {area3_latency_hi_i, area3_latency_lo_i}
                                 : {area2_latency_hi_i, area2_latency_lo_i};
  assign ref_due   = refresh_enable_i && (refresh_mode_select_i || ref_pend_ff)
                     && all_free;
  assign pop       = go_col && cur.write;
  // Write recovery is stacked ahead of the precharge wait
  assign busy_val  = cur.write ? CNT_W'(write_recovery_i) + CNT_W'(precharge_wait_i)
                               : CNT_W'(precharge_wait_i);

  // Requests wait for the bank timer and, for writes, all their data
  assign req_ready_o = (state_ff == ST_IDLE) && !ref_due && !bus_release_i
                       && free[req_bank]
                       && (!req_i.write || (CNT_W'(fifo_level) >= req_beats));

  // ***************************************************************
  // Command sequencing: decides the command of the next bus cycle
  // ***************************************************************
  always_comb begin
    nxt_state = state_ff;
    nxt_cmd   = CMD_NOP;
    nxt_pin   = pin_ff;
    nxt_cnt   = (cnt_ff != '0) ? cnt_ff - 1'b1 : cnt_ff;
    nxt_beat  = beat_ff;
    nxt_cke   = cke_ff;
    take      = 1'b0;
    go_col    = 1'b0;
    ld_busy   = 1'b0;
    close_all = 1'b0;
    unique case (state_ff)
      ST_IDLE: begin
        if (ref_due) begin
          nxt_state = ST_RFT;
          nxt_cmd   = CMD_PRE;
          nxt_pin   = pre_pins(req_ff.addr, 1'b1);
          nxt_cnt   = tpc_cnt;
        end else if (req_ready_o && req_valid_i) begin
          take = 1'b1;
          if (hit) begin
            if (!cur.write && (lat_now <= LAT_MIN)) begin
              nxt_state = ST_NOP;
            end else begin
              go_col = 1'b1;
            end
          end else if (bank_active_enable_i && open_ff[bank]) begin
            nxt_state = ST_TPC;
            nxt_cmd   = CMD_PRE;
            nxt_pin   = pre_pins(cur.addr, 1'b0);
            nxt_cnt   = tpc_cnt;
          end else begin
            nxt_state = ST_ACT;
            nxt_cmd   = CMD_ACTV;
            nxt_pin   = row_pins(cur.addr);
          end
        end
      end
      ST_TPC: begin
        if (cnt_ff <= CNT_W'(1)) begin
          nxt_state = ST_ACT;
          nxt_cmd   = CMD_ACTV;
          nxt_pin   = row_pins(cur.addr);
        end
      end
      ST_ACT: begin
        if (row_to_col_delay_i == '0) begin
          go_col = 1'b1;
        end else begin
          nxt_state = ST_GAP;
          nxt_cnt   = CNT_W'(row_to_col_delay_i);
        end
      end
      ST_GAP: begin
        if (cnt_ff <= CNT_W'(1)) begin
          go_col = 1'b1;
        end
      end
      ST_NOP: begin
        go_col = 1'b1;
      end
      ST_COL: begin
        go_col = 1'b1;
      end
      ST_DRAIN: begin
        if ((rd_pipe_ff == '0) && (cmd_ff != CMD_READ)) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_RFT: begin
        if (cnt_ff <= CNT_W'(1)) begin
          nxt_cmd   = CMD_REF;
          close_all = 1'b1;
          if (refresh_mode_select_i) begin
            nxt_state = ST_SELF;
            nxt_cke   = 1'b0;
          end else begin
            nxt_state = ST_RFH;
            nxt_cnt   = CNT_W'(row_active_time_i) + tpc_cnt;
          end
        end
      end
      ST_RFH: begin
        if (cnt_ff <= CNT_W'(1)) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_SELF: begin
        if (!refresh_mode_select_i) begin
          nxt_state = ST_RFH;
          nxt_cke   = 1'b1;
          nxt_cnt   = tpc_cnt;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    if (go_col) begin
      nxt_cmd = cur.write ? CMD_WRIT : CMD_READ;
      // Auto-precharge only on the last beat and only outside bank-active mode
      nxt_pin = col_pins(wrap_addr(cur.addr, beat_ff, bus16_i),
                         (beat_ff == last_beat) && !bank_active_enable_i);
      if (beat_ff == last_beat) begin
        nxt_state = cur.write ? ST_IDLE : ST_DRAIN;
        nxt_beat  = '0;
        ld_busy   = !bank_active_enable_i;
      end else begin
        nxt_state = ST_COL;
        nxt_beat  = beat_ff + 1'b1;
      end
    end
  end

  // State, counters and the captured request
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_ff <= ST_IDLE;
      cnt_ff   <= '0;
      beat_ff  <= '0;
      req_ff   <= '0;
      lat_ff   <= LAT_MIN;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      beat_ff  <= nxt_beat;
      if (take) begin
        req_ff <= req_i;
        lat_ff <= (lat_now == '0) ? LAT_MIN : lat_now;
      end
    end
  end

  // Pending auto-refresh; a new request merges with a waiting one
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ref_pend_ff <= 1'b0;
    end else if (refresh_req_i) begin
      ref_pend_ff <= 1'b1;
    end else if (close_all) begin
      ref_pend_ff <= 1'b0;
    end
  end

  // ***************************************************************
  // Per-bank open row and precharge timer
  // ***************************************************************
  for (genvar b = 0; b < BANKS; b++) begin : g_bank
    assign free[b] = (busy_ff[b] == '0);
    always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
        busy_ff[b] <= '0;
        open_ff[b] <= 1'b0;
        row_ff[b]  <= '0;
      end else begin
        if (ld_busy && (bank == BANK_W'(b))) begin
          busy_ff[b] <= busy_val;
        end else if (busy_ff[b] != '0) begin
          busy_ff[b] <= busy_ff[b] - 1'b1;
        end
        if (close_all || (bus_release_i && (state_ff == ST_IDLE))) begin
          open_ff[b] <= 1'b0;
        end else if (go_col && (nxt_beat == '0) && (bank == BANK_W'(b))) begin
          open_ff[b] <= bank_active_enable_i;
          row_ff[b]  <= row_tag(cur.addr);
        end
      end
    end
  end

  // ***************************************************************
  // Pin registers
  // ***************************************************************
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cmd_ff   <= CMD_NOP;
      pin_ff   <= '0;
      cke_ff   <= 1'b1;
      dq_ff    <= '0;
      dq_oe_ff <= 1'b0;
    end else begin
      cmd_ff   <= nxt_cmd;
      pin_ff   <= nxt_pin;
      cke_ff   <= nxt_cke;
      dq_oe_ff <= pop;
      if (pop) begin
        dq_ff <= fifo_data;
      end
    end
  end

  // Byte masks go out at accept, with or ahead of the column command, for their latency
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bmask_ff <= MASK_NONE;
    end else if (take) begin
      bmask_ff <= req_i.burst ? MASK_ALL : lane_mask(req_i.byte_en, big_endian_i);
    end else if (state_ff == ST_IDLE) begin
      bmask_ff <= MASK_NONE;
    end
  end

  // ***************************************************************
  // Read capture after the CAS latency
  // ***************************************************************
  assign capture = rd_pipe_ff[lat_ff - LAT_MIN];

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_pipe_ff  <= '0;
      rd_valid_ff <= 1'b0;
      rd_data_ff  <= '0;
    end else begin
      rd_pipe_ff  <= {rd_pipe_ff[1:0], (cmd_ff == CMD_READ)};
      rd_valid_ff <= capture;
      if (capture) begin
        rd_data_ff <= dq_i;
      end
    end
  end

  assign sd_addr_o   = pin_ff;
  assign ras_n_o     = cmd_ff[2];
  assign cas_n_o     = cmd_ff[1];
  assign we_n_o      = cmd_ff[0];
  assign cke_o       = cke_ff;
  assign dq_o        = dq_ff;
  assign dq_oe_o     = dq_oe_ff;
  assign rd_valid_o  = rd_valid_ff;
  assign rd_data_o   = rd_data_ff;
  assign byte_mask_outputs_o      = bmask_ff;
  assign bus_cycle_start_strobe_o = capture || dq_oe_ff;

endmodule : sas_sequencer

// ### design/sas_unused.sv
// Holds no logic; every module of the sequencer sits in sas_sequencer.sv
`timescale 1ns/1ps
